// ==== ipc_map.svh ====
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

// register offsets on the serial register link
`define IPC_ADDR_SOFT_RESET   8'h0F
`define IPC_ADDR_TABLE_LOAD   8'h15
`define IPC_ADDR_STEP_START   8'h16
`define IPC_ADDR_STEP_END     8'h17
`define IPC_ADDR_STEP_CTRL    8'h18
`define IPC_ADDR_COLOR_FIRST  8'h20
`define IPC_ADDR_COLOR_SECOND 8'h21

// widths
`define IPC_DATA_W            16
`define IPC_ADDR_W            8
`define IPC_Q_W               12
`define IPC_GAIN_W            10
`define IPC_CUTOFF_W          8
`define IPC_TABLE_DEPTH       512

// reset values
`define IPC_STEP_START_RESET  12'h010
`define IPC_STEP_END_RESET    12'h020
`define IPC_STEP_CTRL_RESET   12'h100
`define IPC_COLOR_FIRST_RESET 16'h0000
`define IPC_COLOR_SECOND_RESET 16'h0000

// field positions
`define IPC_SOFT_RESET_BIT    0
`define IPC_STEP_ENA_BIT      9
`define IPC_FREEZE_BIT        15
`define IPC_FOUR_CHANNEL_BIT  14

`endif

// ==== ipc_pkg.sv ====
`include "ipc_map.svh"

package ipc_pkg;

    // one register access from the serial link engine
    typedef struct packed {
        logic                     write;
        logic                     read;
        logic [`IPC_ADDR_W-1:0]   addr;
        logic [`IPC_DATA_W-1:0]   wdata;
    } ipc_reg_req_type;

    // first color pipeline control word, msb first as stored
    typedef struct packed {
        logic       interpolation_skip;
        logic [1:0] reserved_hi;
        logic       correction_filter_select;
        logic       color_bypass;
        logic       display_gain_on;
        logic       auto_exposure_on;
        logic       transmission_correction_on;
        logic       reserved_mid;
        logic       median_off;
        logic       white_balance_on;
        logic       crosstalk_on;
        logic       balance_realign_on;
        logic       recompress_on;
        logic       decompress_on;
        logic       dark_lowpass_on;
    } ipc_color_ctrl_type;

    // second color pipeline control word
    typedef struct packed {
        logic                     balance_freeze;
        logic                     four_channel_balance_sel;
        logic [5:0]               reserved;
        logic [`IPC_CUTOFF_W-1:0] dark_image_cutoff;
    } ipc_balance_ctrl_type;

endpackage

// ==== ipc_threshold_table.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ipc_map.svh"

module ipc_threshold_table #(
    parameter int DEPTH = `IPC_TABLE_DEPTH,
    parameter int WIDTH = `IPC_Q_W
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       load_valid,
    input  wire logic [WIDTH-1:0]           load_q,
    input  wire logic [$clog2(DEPTH)-1:0]   rd_index,
    output logic      [WIDTH-1:0]           rd_q,
    output logic      [$clog2(DEPTH+1)-1:0] load_count,
    output logic                            full
);
    import ipc_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);
    localparam int PTR_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] table_mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PTR_W-1:0] next_load_count;
    logic [WIDTH-1:0] next_rd_q;

    assign full = (load_count == PTR_W'(DEPTH));

    ////////////////////////////////////////////////////////////////////////////
    // sequential load: pointer starts at entry 0 and only walks forward
    always_comb
    begin
        next_mem        = table_mem;
        next_load_count = load_count;
        next_rd_q       = table_mem[rd_index];
        if (reset)
        begin
            for (int i = 0; i < DEPTH; i++)
                next_mem[i] = '0;
            next_load_count = '0; // R1
            next_rd_q       = '0;
        end
        else if (load_valid && !full) // R26
        begin
            next_mem[load_count[IDX_W-1:0]] = load_q; // R2
            next_load_count = load_count + PTR_W'(1); // R1
        end
    end

    always_ff @(posedge clk)
    begin
        table_mem  <= next_mem;
        load_count <= next_load_count;
        rd_q       <= next_rd_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_load_advances;
        @(posedge clk) disable iff (reset)
        load_valid && !full |=> load_count == $past(load_count) + PTR_W'(1);
    endproperty
    a_load_advances: assert property (p_load_advances) else $error("table pointer did not advance"); // R1

    property p_full_ignored;
        @(posedge clk) disable iff (reset)
        full |=> full && table_mem[0] == $past(table_mem[0]);
    endproperty
    a_full_ignored: assert property (p_full_ignored) else $error("write taken after table full"); // R26

endmodule

`default_nettype wire

// ==== ipc_step_select.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ipc_map.svh"

module ipc_step_select (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [`IPC_Q_W-1:0] gray_level,
    input  wire logic [`IPC_Q_W-1:0] q_start,
    input  wire logic [`IPC_Q_W-1:0] q_end,
    input  wire logic [`IPC_Q_W-1:0] transition,
    input  wire logic               step_ena,
    input  wire logic               draw_engine_on,
    output logic      [`IPC_Q_W-1:0] step_q,
    output logic                    step_active
);
    import ipc_pkg::*;

    logic [`IPC_Q_W-1:0] next_step_q;
    logic                next_step_active;

    ////////////////////////////////////////////////////////////////////////////
    // threshold for the gray level the engine asks about, one cycle later
    always_comb
    begin
        next_step_active = step_ena && draw_engine_on; // R5
        next_step_q      = (gray_level < transition) ? q_start : q_end; // R3
        if (reset)
        begin
            next_step_active = 1'b0;
            next_step_q      = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        step_q      <= next_step_q;
        step_active <= next_step_active;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_step_level;
        @(posedge clk) disable iff (reset)
        gray_level >= transition |=> step_q == $past(q_end);
    endproperty
    a_step_level: assert property (p_step_level) else $error("end threshold not used past transition"); // R3

endmodule

`default_nettype wire

// ==== ipc_control_regs.sv ====
// What this block does
// R1 - after any reset the first table write lands at entry 0, then next entries
// R2 - the threshold table holds 512 entries, one per gray level
// R3 - step mode: start threshold below transition level, end threshold from it onward
// R4 - reset loads start 0x010, end 0x020, transition 0x100, step disabled
// R5 - step thresholds apply only while the drawing engine is enabled
// R6 - bit 9 of step control enables the step function, overlapping the transition
// R7 - color control bit 15 routes pixels around the interpolation filter
// R8 - color control bit 11 skips every stage after interpolation
// R9 - color control bit 12 selects one of two correction filters
// R10 - color control bit 10 applies the dark-scene display gain
// R11 - color control bit 9 runs autoexposure
// R12 - color control bit 8 enables the filter transmission correction matrix
// R13 - color control bit 6 disables the median filter stage
// R14 - color control bit 4 enables crosstalk artifact suppression
// R15 - bit 3 realigns white balance positions; software keeps it consistent
// R16 - bit 2 enables recompression, bit 1 decompression before crosstalk and balance
// R17 - bit 0 enables the three-tap horizontal low-pass for dark images
// R18 - software leaves reserved color control bits unchanged on writes
// R19 - second control bit 15 freezes white balance coefficients
// R20 - second control bit 14 picks four-channel or three-channel balance
// R21 - no new white point coefficients once image average falls to cutoff
// R22 - in three-channel mode both greens use the first green gain
// R23 - writing one to soft reset returns all registers and pointer to power-on
// R24 - software reads 16-bit values as two bytes and should read twice
// R25 - color control bit 5 enables automatic white balance
// R26 - after 512 table writes further loads are ignored until reset
`timescale 1ns/10ps
`default_nettype none
`include "ipc_map.svh"

module ipc_control_regs #(
    parameter logic [`IPC_DATA_W-1:0] COLOR_FIRST_RESET  = `IPC_COLOR_FIRST_RESET,
    parameter logic [`IPC_DATA_W-1:0] COLOR_SECOND_RESET = `IPC_COLOR_SECOND_RESET,
    parameter int                     TABLE_DEPTH        = `IPC_TABLE_DEPTH
) (
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire ipc_pkg::ipc_reg_req_type            reg_req,
    output logic                 [`IPC_DATA_W-1:0]   reg_rdata,
    input  wire logic                                draw_engine_on,
    input  wire logic            [`IPC_Q_W-1:0]      gray_level,
    output logic                 [`IPC_Q_W-1:0]      step_q,
    output logic                                     step_active,
    input  wire logic            [$clog2(TABLE_DEPTH)-1:0] table_rd_index,
    output logic                 [`IPC_Q_W-1:0]      table_rd_q,
    output logic                                     table_full,
    input  wire logic            [`IPC_CUTOFF_W-1:0] image_average,
    input  wire logic            [`IPC_GAIN_W-1:0]   first_green_gain,
    input  wire logic            [`IPC_GAIN_W-1:0]   second_green_gain,
    output logic                 [`IPC_GAIN_W-1:0]   green2_gain_applied,
    output ipc_pkg::ipc_color_ctrl_type              color_ctrl,
    output ipc_pkg::ipc_balance_ctrl_type            balance_ctrl,
    output logic                                     balance_update_allow
);
    import ipc_pkg::*;

    localparam int PTR_W = $clog2(TABLE_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [`IPC_Q_W-1:0]    step_start;
    logic [`IPC_Q_W-1:0]    step_end;
    logic [`IPC_Q_W-1:0]    step_ctrl;
    logic                   soft_reset;
    logic [`IPC_Q_W-1:0]    next_step_start;
    logic [`IPC_Q_W-1:0]    next_step_end;
    logic [`IPC_Q_W-1:0]    next_step_ctrl;
    ipc_color_ctrl_type     next_color_ctrl;
    ipc_balance_ctrl_type   next_balance_ctrl;
    logic                   next_soft_reset;
    logic [`IPC_DATA_W-1:0] next_reg_rdata;
    logic                   next_balance_update_allow;
    logic [`IPC_GAIN_W-1:0] next_green2_gain_applied;
    logic                   all_reset;
    logic                   table_load;
    logic [PTR_W-1:0]       table_count;

    // one write strobe to one offset; used by every register below
    function automatic logic write_hit(input ipc_reg_req_type req,
                                       input logic [`IPC_ADDR_W-1:0] target);
        write_hit = req.write && (req.addr == target);
    endfunction

    // narrow register padded with zero above its field on read
    function automatic logic [`IPC_DATA_W-1:0] pad_q(input logic [`IPC_Q_W-1:0] q);
        pad_q = {{(`IPC_DATA_W - `IPC_Q_W){1'b0}}, q};
    endfunction

    // soft reset reaches every register one cycle after the write
    assign all_reset  = reset || soft_reset; // R23
    assign table_load = write_hit(reg_req, `IPC_ADDR_TABLE_LOAD);

    ////////////////////////////////////////////////////////////////////////////
    // register writes; reserved bits are stored as written so that a
    // read-modify-write by software keeps them
    always_comb
    begin
        next_step_start   = step_start;
        next_step_end     = step_end;
        next_step_ctrl    = step_ctrl;
        next_color_ctrl   = color_ctrl;
        next_balance_ctrl = balance_ctrl;
        next_soft_reset   = 1'b0;
        if (all_reset)
        begin
            next_step_start   = `IPC_STEP_START_RESET; // R4
            next_step_end     = `IPC_STEP_END_RESET; // R4
            next_step_ctrl    = `IPC_STEP_CTRL_RESET; // R4
            next_color_ctrl   = COLOR_FIRST_RESET;
            next_balance_ctrl = COLOR_SECOND_RESET;
        end
        else
        begin
            if (write_hit(reg_req, `IPC_ADDR_STEP_START))
                next_step_start = reg_req.wdata[`IPC_Q_W-1:0];
            if (write_hit(reg_req, `IPC_ADDR_STEP_END))
                next_step_end = reg_req.wdata[`IPC_Q_W-1:0];
            // enable bit sits inside the transition field by layout
            if (write_hit(reg_req, `IPC_ADDR_STEP_CTRL))
                next_step_ctrl = reg_req.wdata[`IPC_Q_W-1:0]; // R6
            // every pipeline enable is a plain stored bit driven out as is
            if (write_hit(reg_req, `IPC_ADDR_COLOR_FIRST))
                next_color_ctrl = reg_req.wdata; // R7 R8 R9 R10 R11 R12 R13 R14 R15 R16 R17 R25
            if (write_hit(reg_req, `IPC_ADDR_COLOR_SECOND))
                next_balance_ctrl = reg_req.wdata; // R19 R20
            next_soft_reset = write_hit(reg_req, `IPC_ADDR_SOFT_RESET)
                              && reg_req.wdata[`IPC_SOFT_RESET_BIT]; // R23
        end
    end

    always_ff @(posedge clk)
    begin
        step_start   <= next_step_start;
        step_end     <= next_step_end;
        step_ctrl    <= next_step_ctrl;
        color_ctrl   <= next_color_ctrl;
        balance_ctrl <= next_balance_ctrl;
        soft_reset   <= next_soft_reset;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: word valid the cycle after the read strobe, held until the
    // next read; the link engine splits it into bytes, so a value that moves
    // between the two byte reads is the host's to catch by reading twice
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        if (all_reset)
            next_reg_rdata = '0;
        else if (reg_req.read)
        begin
            unique case (reg_req.addr)
                `IPC_ADDR_STEP_START:   next_reg_rdata = pad_q(step_start);
                `IPC_ADDR_STEP_END:     next_reg_rdata = pad_q(step_end);
                `IPC_ADDR_STEP_CTRL:    next_reg_rdata = pad_q(step_ctrl);
                `IPC_ADDR_COLOR_FIRST:  next_reg_rdata = color_ctrl;
                `IPC_ADDR_COLOR_SECOND: next_reg_rdata = balance_ctrl;
                default:                next_reg_rdata = '0; // write-only and foreign offsets
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        reg_rdata <= next_reg_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // white balance gating and green gain sharing, registered toward the pipe
    always_comb
    begin
        next_balance_update_allow = color_ctrl.white_balance_on // R25
                                    && !balance_ctrl.balance_freeze // R19
                                    && (image_average > balance_ctrl.dark_image_cutoff); // R21
        next_green2_gain_applied  = balance_ctrl.four_channel_balance_sel
                                    ? second_green_gain
                                    : first_green_gain; // R20 R22
        if (all_reset)
        begin
            next_balance_update_allow = 1'b0;
            next_green2_gain_applied  = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        balance_update_allow <= next_balance_update_allow;
        green2_gain_applied  <= next_green2_gain_applied;
    end

    ////////////////////////////////////////////////////////////////////////////
    // table and step-function lookups
    ipc_threshold_table #(
        .DEPTH (TABLE_DEPTH),
        .WIDTH (`IPC_Q_W)
    ) u_table (
        .clk        (clk),
        .reset      (all_reset),
        .load_valid (table_load),
        .load_q     (reg_req.wdata[`IPC_Q_W-1:0]),
        .rd_index   (table_rd_index),
        .rd_q       (table_rd_q),
        .load_count (table_count),
        .full       (table_full)
    );

    ipc_step_select u_step (
        .clk            (clk),
        .reset          (all_reset),
        .gray_level     (gray_level),
        .q_start        (step_start),
        .q_end          (step_end),
        .transition     (step_ctrl),
        .step_ena       (step_ctrl[`IPC_STEP_ENA_BIT]),
        .draw_engine_on (draw_engine_on),
        .step_q         (step_q),
        .step_active    (step_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_reset_values;
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> step_start == `IPC_STEP_START_RESET && step_end == `IPC_STEP_END_RESET
                         && step_ctrl == `IPC_STEP_CTRL_RESET && !step_active;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("step registers wrong after reset"); // R4

    property p_first_after_reset;
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> table_count == '0;
    endproperty
    a_first_after_reset: assert property (p_first_after_reset) else $error("table pointer not at 0"); // R1

    property p_step_enable;
        @(posedge clk) disable iff (reset)
        write_hit(reg_req, `IPC_ADDR_STEP_CTRL) && !all_reset && draw_engine_on
        ##1 draw_engine_on |=> step_active == $past(reg_req.wdata[`IPC_STEP_ENA_BIT], 2);
    endproperty
    a_step_enable: assert property (p_step_enable) else $error("step enable not following bit 9"); // R6

    property p_engine_gate;
        @(posedge clk) disable iff (all_reset)
        !draw_engine_on |=> !step_active;
    endproperty
    a_engine_gate: assert property (p_engine_gate) else $error("step active without engine"); // R5

    property p_color_write;
        @(posedge clk) disable iff (reset)
        write_hit(reg_req, `IPC_ADDR_COLOR_FIRST) && !all_reset
        |=> color_ctrl.interpolation_skip == $past(reg_req.wdata[15])
            && color_ctrl.dark_lowpass_on == $past(reg_req.wdata[0]);
    endproperty
    a_color_write: assert property (p_color_write) else $error("color control not stored"); // R7

    property p_freeze;
        @(posedge clk) disable iff (all_reset)
        balance_ctrl.balance_freeze |=> !balance_update_allow;
    endproperty
    a_freeze: assert property (p_freeze) else $error("balance updated while frozen"); // R19

    property p_cutoff;
        @(posedge clk) disable iff (all_reset)
        image_average <= balance_ctrl.dark_image_cutoff |=> !balance_update_allow;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("balance updated below cutoff"); // R21

    property p_three_channel_green;
        @(posedge clk) disable iff (all_reset)
        !balance_ctrl.four_channel_balance_sel |=> green2_gain_applied == $past(first_green_gain);
    endproperty
    a_three_channel_green: assert property (p_three_channel_green) else $error("second green not shared"); // R22

    property p_soft_reset;
        @(posedge clk) disable iff (reset)
        write_hit(reg_req, `IPC_ADDR_SOFT_RESET) && reg_req.wdata[`IPC_SOFT_RESET_BIT] && !all_reset
        |-> ##2 step_start == `IPC_STEP_START_RESET && table_count == '0
                && color_ctrl == COLOR_FIRST_RESET;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore registers"); // R23

    property p_four_channel_green;
        @(posedge clk) disable iff (all_reset)
        balance_ctrl.four_channel_balance_sel |=> green2_gain_applied == $past(second_green_gain);
    endproperty
    a_four_channel_green: assert property (p_four_channel_green) else $error("green2 not second gain"); // R20

    property p_balance_off;
        @(posedge clk) disable iff (all_reset)
        !color_ctrl.white_balance_on |=> !balance_update_allow;
    endproperty
    a_balance_off: assert property (p_balance_off) else $error("balance updated while disabled"); // R25

    property p_step_disabled;
        @(posedge clk) disable iff (all_reset)
        !step_ctrl[`IPC_STEP_ENA_BIT] |=> !step_active;
    endproperty
    a_step_disabled: assert property (p_step_disabled) else $error("step active with enable clear"); // R6

    // the table load port is write-only, so a read of it must return zero
    property p_write_only_read;
        @(posedge clk) disable iff (all_reset)
        reg_req.read && reg_req.addr == `IPC_ADDR_TABLE_LOAD |=> reg_rdata == '0;
    endproperty
    a_write_only_read: assert property (p_write_only_read) else $error("load port read not zero");

endmodule

`default_nettype wire

// ==== tb_image_pipeline_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ipc_map.svh"

module tb_image_pipeline_control_regs;
    import ipc_pkg::*;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    ipc_reg_req_type      reg_req = '0;
    logic [15:0]          reg_rdata;
    logic                 draw_engine_on = 1'b0;
    logic [11:0]          gray_level = '0;
    logic [11:0]          step_q;
    logic                 step_active;
    logic [8:0]           table_rd_index = '0;
    logic [11:0]          table_rd_q;
    logic                 table_full;
    logic [7:0]           image_average = '0;
    logic [9:0]           first_green_gain = 10'h100;
    logic [9:0]           second_green_gain = 10'h2C0;
    logic [9:0]           green2_gain_applied;
    ipc_color_ctrl_type   color_ctrl;
    ipc_balance_ctrl_type balance_ctrl;
    logic                 balance_update_allow;
    int                   err_count = 0;
    int                   n_tests = 0;
    int                   cycles = 0;
    int                   bits[13] = '{15, 12, 11, 10, 9, 8, 6, 5, 4, 3, 2, 1, 0};

    ipc_control_regs i_ipc_control_regs (
        .clk                  (clk),
        .reset                (reset),
        .reg_req              (reg_req),
        .reg_rdata            (reg_rdata),
        .draw_engine_on       (draw_engine_on),
        .gray_level           (gray_level),
        .step_q               (step_q),
        .step_active          (step_active),
        .table_rd_index       (table_rd_index),
        .table_rd_q           (table_rd_q),
        .table_full           (table_full),
        .image_average        (image_average),
        .first_green_gain     (first_green_gain),
        .second_green_gain    (second_green_gain),
        .green2_gain_applied  (green2_gain_applied),
        .color_ctrl           (color_ctrl),
        .balance_ctrl         (balance_ctrl),
        .balance_update_allow (balance_update_allow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and a hang guard; the table fill dominates run time
    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one strobe per access, held exactly one edge, sampled after it lands
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{write: w, read: !w, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk("reg_rdata", reg_rdata, exp);
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic look(input logic [11:0] g, input logic [11:0] exp);
        @(posedge clk);
        gray_level <= g;
        tick();
        chk("step_q", {4'h0, step_q}, {4'h0, exp});
    endtask

    task automatic entry(input logic [8:0] i, input logic [11:0] exp);
        @(posedge clk);
        table_rd_index <= i;
        tick();
        chk("table_rd_q", {4'h0, table_rd_q}, {4'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd(8'h16, 16'h0010);
        rd(8'h17, 16'h0020);
        rd(8'h18, 16'h0100);
        rd(8'h33, 16'h0000);
        rd(8'h15, 16'h0000);
        chk("step_active", {15'h0, step_active}, 16'h0000);
    endtask

    // transition 0x280 also carries the enable in bit 9
    task automatic test_step();
        acc(1'b1, 8'h18, 16'h0280);
        @(posedge clk);
        draw_engine_on <= 1'b1;
        look(12'h27F, 12'h010);
        look(12'h280, 12'h020);
        look(12'hFFF, 12'h020);
        chk("step_active", {15'h0, step_active}, 16'h0001);
        acc(1'b1, 8'h18, 16'h0080);
        tick();
        chk("step_active", {15'h0, step_active}, 16'h0000);
        acc(1'b1, 8'h18, 16'h0280);
        acc(1'b1, 8'h16, 16'hF123);
        rd(8'h16, 16'h0123);
        rd(8'h16, 16'h0123);
        look(12'h000, 12'h123);
        @(posedge clk);
        draw_engine_on <= 1'b0;
        tick();
        chk("step_active", {15'h0, step_active}, 16'h0000);
    endtask

    task automatic test_color();
        foreach (bits[k])
        begin
            acc(1'b1, 8'h20, 16'h0001 << bits[k]);
            chk("color_ctrl", color_ctrl, 16'h0001 << bits[k]);
            rd(8'h20, 16'h0001 << bits[k]);
        end
    endtask

    task automatic test_balance();
        acc(1'b1, 8'h20, 16'h0020);
        acc(1'b1, 8'h21, 16'h4040);
        rd(8'h21, 16'h4040);
        @(posedge clk);
        image_average <= 8'h41;
        tick();
        chk("green2", {6'h0, green2_gain_applied}, 16'h02C0);
        chk("allow", {15'h0, balance_update_allow}, 16'h0001);
        @(posedge clk);
        image_average <= 8'h40;
        tick();
        chk("allow", {15'h0, balance_update_allow}, 16'h0000);
        acc(1'b1, 8'h21, 16'h8040);
        @(posedge clk);
        image_average <= 8'h41;
        tick();
        chk("allow", {15'h0, balance_update_allow}, 16'h0000);
        acc(1'b1, 8'h21, 16'h0040);
        tick();
        chk("green2", {6'h0, green2_gain_applied}, 16'h0100);
    endtask

    // fill every entry, overrun once, then soft reset must rewind the pointer
    task automatic test_table();
        for (int i = 0; i < 512; i++)
            acc(1'b1, 8'h15, 16'(i ^ 12'hA5A));
        chk("table_full", {15'h0, table_full}, 16'h0001);
        acc(1'b1, 8'h15, 16'h0FFF);
        entry(9'd0, 12'hA5A);
        entry(9'd1, 12'hA5B);
        entry(9'd511, 12'hBA5);
        acc(1'b1, 8'h0F, 16'h0001);
        tick();
        chk("table_full", {15'h0, table_full}, 16'h0000);
        rd(8'h18, 16'h0100);
        rd(8'h20, 16'h0000);
        acc(1'b1, 8'h15, 16'h0777);
        entry(9'd0, 12'h777);
        entry(9'd1, 12'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_step();
        test_color();
        test_balance();
        test_table();
        print_verdict();
    end
endmodule

`default_nettype wire
